// file: hdl/extended_command_write_guard.sv
// per-group command write guard with passkey unlock and boot-time reload
`default_nettype none
// Overview of operation
// (R1) protection word is word command FBh
// (R2) each bit except bit 0 gates its own command group
// (R3) bit 15 locks word and passkey
// (R4) passkey lock also blocks word
// (R5) bit 14 alone governs write-protect command
// (R6) bit 13 locks trim and calibration commands
// (R7) bit 12 locks output mode and setpoint
// (R8) bit 11 locks output limits and responses
// (R9) bit 10 locks warning limits and mask
// (R10) bit 9 locks current/temperature faults, simulation
// (R11) bit 8 locks margins and transition rate
// (R12) bit 7 locks operation command
// (R13) bit 6 locks configuration commands
// (R14) bit 5 locks input limits
// (R15) bit 4 locks sequencing commands
// (R16) bit 3 locks identity data commands
// (R17) bit 2 locks override and address
// (R18) bit 1 locks passkey command
// (R19) bit 1 with zero passkey blocks programming
// (R20) nonzero boot passkey blocks word and store
// (R21) three mismatches lock passkey until power-on
// (R22) word and passkey load from backup at boot
// (R23) refused write keeps value, flags invalid
module extended_command_write_guard (
    input  wire logic            clk,             // bus/control clock
    input  wire logic            sys_rst,         // synchronous, active high
    input  wire logic            por,             // power-on reset, clears passkey lockout
    input  wire logic            boot_load,       // one-cycle pulse: take backup values
    input  wire logic [15:0]     nvm_ewp,         // backed-up protection word
    input  wire logic [15:0]     nvm_unlock_code, // backed-up passkey
    input  wire ewp_pkg::wr_req_t wr_req,         // host write word
    input  wire logic            wp_blocks,       // standard write-protect blocks this cmd
    input  wire logic            rd_req,          // host read word strobe
    input  wire logic [7:0]      rd_cmd,          // command read
    output logic                 wr_accept,       // pulse: write may be committed
    output logic                 wr_invalid,      // pulse: refused, invalid communication
    output logic [15:0]          rd_data,         // read answer for FA/FB
    output logic                 rd_valid,        // pulse: rd_data valid
    output logic [15:0]          extended_write_protect_word_word, // active protection word
    output logic                 unlock_active    // passkey currently protects
);
    logic [15:0]         extended_write_protect_word; // protection word
    logic [15:0]         boot_code;       // passkey stored at boot
    logic [15:0]         active_code;     // live passkey register
    logic [1:0]          mismatch_cnt;    // consecutive mismatching writes
    ewp_pkg::pk_state_t  pk_state;        // passkey lock state
    logic                group_lock;      // the addressed command is read-only
    logic                cmd_blocked;     // final refusal decision
    // last count before the lockout; declared ahead of the passkey process that reads it
    localparam logic [1:0] MAX_M1 = ewp_pkg::MAX_MISMATCH - 2'h1;

    // command-group decode against the word; new groups go here
    function automatic logic grp_locked(input logic [7:0] c, input logic [15:0] w);
        logic r;
        r = 1'b0;
        case (c)
            8'h22, 8'h29, 8'h38, 8'h39:               r = w[ewp_pkg::TRIM_LOCK_BIT];   // R6
            8'h20, 8'h21:                             r = w[ewp_pkg::SETPOINT_BIT];    // R7
            8'h24, 8'h2B, 8'h40, 8'h41, 8'h44, 8'h45: r = w[ewp_pkg::OUT_FAULT_BIT];   // R8
            8'h42, 8'h43, 8'h4A, 8'h51, 8'h1B:        r = w[ewp_pkg::WARNING_BIT];     // R9
            8'h46, 8'h47, 8'h4F, 8'h50, 8'hE8:        r = w[ewp_pkg::CUR_TEMP_BIT];    // R10
            8'h25, 8'h26, 8'h27:                      r = w[ewp_pkg::MARGIN_BIT];      // R11
            8'h01:                                    r = w[ewp_pkg::OPERATION_BIT];   // R12
            8'h33, 8'h37, 8'hB1, 8'hD7, 8'hD0, 8'hD1,
            8'hD2, 8'hD3, 8'hD4, 8'hEC:               r = w[ewp_pkg::CONFIG_BIT];      // R13
            8'h58, 8'h55, 8'h57, 8'h56:               r = w[ewp_pkg::INPUT_LIMIT_BIT]; // R14
            8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65,
            8'h02, 8'h35, 8'h36:                      r = w[ewp_pkg::SEQUENCING_BIT];  // R15
            8'h99, 8'h9A, 8'h9B, 8'h9E:               r = w[ewp_pkg::IDENTITY_BIT];    // R16
            8'hEE, 8'hEF:                             r = w[ewp_pkg::BOOT_ADDR_BIT];   // R17
            default:                                  r = 1'b0;
        endcase
        return r;
    endfunction

    assign unlock_active = (active_code != ewp_pkg::UNLOCK_ZERO) && (pk_state != ewp_pkg::PK_OPEN);

    // refusal decision, one place for all commands
    always_comb begin
        group_lock  = grp_locked(wr_req.cmd, extended_write_protect_word); // R2
        cmd_blocked = 1'b0;
        case (wr_req.cmd)
            ewp_pkg::CMD_WRITE_PROT: begin
                // no other control may block this command
                cmd_blocked = extended_write_protect_word[ewp_pkg::WP_LOCK_BIT]; // R5
            end
            ewp_pkg::CMD_EXT_WP: begin
                cmd_blocked = extended_write_protect_word[ewp_pkg::SELF_LOCK_BIT] // R3
                            | unlock_active;                                      // R4 R20
            end
            ewp_pkg::CMD_UNLOCK_CODE: begin
                // a correct unlock must still pass while only the passkey itself protects
                cmd_blocked = extended_write_protect_word[ewp_pkg::SELF_LOCK_BIT] // R3
                            | extended_write_protect_word[ewp_pkg::UNLOCK_CODE_BIT] // R18 R19
                            | (pk_state == ewp_pkg::PK_DEAD)                      // R21
                            | wp_blocks;
            end
            ewp_pkg::CMD_STORE_ALL: begin
                cmd_blocked = unlock_active | wp_blocks;                          // R20
            end
            default: begin
                cmd_blocked = group_lock | wp_blocks;                             // R2
            end
        endcase
    end

    // accept/refuse pulses to the command decoder
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_accept  <= 1'b0;
            wr_invalid <= 1'b0;
        end else begin
            wr_accept  <= wr_req.valid & ~cmd_blocked;
            wr_invalid <= wr_req.valid & cmd_blocked;                             // R23
        end
    end

    // protection word: boot reload, then host writes when allowed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            extended_write_protect_word <= ewp_pkg::EWP_RESET;
        end else if (boot_load) begin
            extended_write_protect_word <= nvm_ewp;                               // R22
        end else if (wr_req.valid && wr_req.cmd == ewp_pkg::CMD_EXT_WP && !cmd_blocked) begin
            extended_write_protect_word <= wr_req.data;                           // R1
        end
    end

    // passkey: boot value, unlock matching, mismatch counting
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            boot_code    <= ewp_pkg::UNLOCK_ZERO;
            active_code  <= ewp_pkg::UNLOCK_ZERO;
            pk_state     <= ewp_pkg::PK_OPEN;
            mismatch_cnt <= 2'h0;
        end else if (boot_load) begin
            boot_code    <= nvm_unlock_code;                                      // R22
            active_code  <= nvm_unlock_code;
            pk_state     <= (nvm_unlock_code != ewp_pkg::UNLOCK_ZERO) ? ewp_pkg::PK_LOCKED
                                                                       : ewp_pkg::PK_OPEN;
            mismatch_cnt <= 2'h0;
        end else if (por) begin
            // a power-on reset lifts a dead lockout, as do sys_rst and a boot reload
            pk_state     <= (boot_code != ewp_pkg::UNLOCK_ZERO) ? ewp_pkg::PK_LOCKED
                                                                 : ewp_pkg::PK_OPEN;
            mismatch_cnt <= 2'h0;                                                 // R21
        end else if (wr_req.valid && wr_req.cmd == ewp_pkg::CMD_UNLOCK_CODE && !cmd_blocked) begin
            if (pk_state == ewp_pkg::PK_OPEN) begin
                active_code <= wr_req.data;   // unlocked: write updates live value
            end else if (wr_req.data == boot_code) begin
                pk_state     <= ewp_pkg::PK_OPEN;                                 // R20
                mismatch_cnt <= 2'h0;
            end else if (mismatch_cnt == MAX_M1) begin
                mismatch_cnt <= ewp_pkg::MAX_MISMATCH;
                pk_state     <= ewp_pkg::PK_DEAD;                                 // R21
            end else begin
                mismatch_cnt <= mismatch_cnt + 2'h1;
            end
        end
    end

    // read answers: word value, or passkey status code never the key itself
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data  <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_req && (rd_cmd == ewp_pkg::CMD_EXT_WP
                                || rd_cmd == ewp_pkg::CMD_UNLOCK_CODE);
            if (rd_cmd == ewp_pkg::CMD_EXT_WP) begin
                rd_data <= extended_write_protect_word;                           // R1
            end else if (pk_state == ewp_pkg::PK_OPEN) begin
                rd_data <= ewp_pkg::RD_UNLOCKED;
            end else begin
                case (mismatch_cnt)
                    2'h0:    rd_data <= ewp_pkg::RD_LOCKED0;
                    2'h1:    rd_data <= ewp_pkg::RD_LOCKED1;
                    2'h2:    rd_data <= ewp_pkg::RD_LOCKED2;
                    default: rd_data <= ewp_pkg::RD_LOCKED3;
                endcase
            end
        end
    end

    assign extended_write_protect_word_word = extended_write_protect_word;
endmodule
`default_nettype wire

// file: hdl/ewp_pkg.sv
// package: command codes, protection-word bit positions and passkey constants
`default_nettype none
package ewp_pkg;
    localparam logic [7:0]  CMD_EXT_WP       = 8'hFB;  // protection word command code
    localparam logic [7:0]  CMD_UNLOCK_CODE  = 8'hFA;  // passkey command code
    localparam logic [7:0]  CMD_WRITE_PROT   = 8'h10;  // standard write-protect command
    localparam logic [7:0]  CMD_STORE_ALL    = 8'h15;  // store-user-all command
    localparam logic [15:0] EWP_RESET        = 16'h0000; // word before boot load
    localparam logic [15:0] UNLOCK_ZERO      = 16'h0000;
    localparam logic [15:0] RD_UNLOCKED      = 16'h0000;
    localparam logic [15:0] RD_LOCKED0       = 16'h000F;
    localparam logic [15:0] RD_LOCKED1       = 16'h001F;
    localparam logic [15:0] RD_LOCKED2       = 16'h002F;
    localparam logic [15:0] RD_LOCKED3       = 16'h00FF;
    localparam logic [1:0]  MAX_MISMATCH     = 2'h3;
    // bit positions in the protection word
    localparam int SELF_LOCK_BIT    = 15;
    localparam int WP_LOCK_BIT      = 14;
    localparam int TRIM_LOCK_BIT    = 13;
    localparam int SETPOINT_BIT     = 12;
    localparam int OUT_FAULT_BIT    = 11;
    localparam int WARNING_BIT      = 10;
    localparam int CUR_TEMP_BIT     = 9;
    localparam int MARGIN_BIT       = 8;
    localparam int OPERATION_BIT    = 7;
    localparam int CONFIG_BIT       = 6;
    localparam int INPUT_LIMIT_BIT  = 5;
    localparam int SEQUENCING_BIT   = 4;
    localparam int IDENTITY_BIT     = 3;
    localparam int BOOT_ADDR_BIT    = 2;
    localparam int UNLOCK_CODE_BIT  = 1;
    // write request from the command decoder
    typedef struct packed {
        logic        valid;
        logic [7:0]  cmd;
        logic [15:0] data;
    } wr_req_t;
    // lock state of the passkey
    typedef enum logic [1:0] {
        PK_OPEN   = 2'b00,
        PK_LOCKED = 2'b01,
        PK_DEAD   = 2'b11
    } pk_state_t;
endpackage
`default_nettype wire

// file: test/ewp_checker_properties.sv
// checker: locking and answer properties at the guard ports
`default_nettype none
module ewp_checker (
    input wire logic             clk,
    input wire logic             sys_rst,
    input wire logic             boot_load,
    input wire logic [15:0]      nvm_ewp,
    input wire ewp_pkg::wr_req_t wr_req,
    input wire logic             wp_blocks,
    input wire logic             wr_accept,
    input wire logic             wr_invalid,
    input wire logic [15:0]      extended_write_protect_word_word,
    input wire logic             unlock_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic        wv = wr_req.valid;                                 // a write is requested, accepted or refused
    wire logic        fb = wv && wr_req.cmd == ewp_pkg::CMD_EXT_WP;      // protection word write
    wire logic        fa = wv && wr_req.cmd == ewp_pkg::CMD_UNLOCK_CODE; // passkey write
    wire logic [15:0] w  = extended_write_protect_word_word;                       // active word
    a_self_lock: assert property (fb && w[15] |=> wr_invalid)
        else $error("word write not refused under self lock");
    a_key_gate: assert property (fb && unlock_active |=> wr_invalid)
        else $error("word write not refused while passkey protects");
    a_key_bit: assert property (fa && w[1] |=> wr_invalid)
        else $error("passkey write not refused");
    a_wp_alone: assert property (wv && wr_req.cmd == ewp_pkg::CMD_WRITE_PROT |=>
        wr_invalid == $past(w[14])) else $error("write-protect command gated wrongly");
    a_op_gate: assert property (wv && wr_req.cmd == 8'h01 |=>
        wr_invalid == $past(w[7] || wp_blocks)) else $error("operation command gated wrongly");
    a_one_reply: assert property (wv |=> wr_accept != wr_invalid)
        else $error("write not answered by exactly one pulse");
    // boot reload may legally move the word in the same cycle
    a_refused_keep: assert property (wr_invalid && !$past(boot_load) |-> $stable(w))
        else $error("refused write changed the word");
    a_word_store: assert property (fb ##1 wr_accept |-> w == $past(wr_req.data))
        else $error("accepted word not stored");
    a_boot_load: assert property (boot_load |=> w == $past(nvm_ewp))
        else $error("boot reload not taken");
endmodule
bind extended_command_write_guard ewp_checker i_chk (.clk, .sys_rst, .boot_load, .nvm_ewp,
    .wr_req, .wp_blocks, .wr_accept, .wr_invalid, .extended_write_protect_word_word, .unlock_active);
`default_nettype wire

// file: test/pmbus_host_model.sv
// host model: issues word writes and reads on the guard's command side
`default_nettype none
module pmbus_host_model (
    input  wire logic            clk,
    output var ewp_pkg::wr_req_t wr_req,
    output logic                 wp_blocks,
    output logic                 rd_req,
    output logic [7:0]           rd_cmd,
    input  wire logic            wr_accept,
    input  wire logic            wr_invalid,
    input  wire logic [15:0]     rd_data,
    input  wire logic            rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_req, wp_blocks, rd_req, rd_cmd} = '0; // idle from time zero
    // one word transfer, r selects a read; the answer is taken one edge after the request
    task automatic xfer(input logic r, input logic [7:0] c, input logic [15:0] d,
                        input logic p, output logic [18:0] ans);
        @(posedge clk) #1 {wr_req, wp_blocks, rd_req, rd_cmd} = {~r, c, d, p, r, c};
        @(posedge clk) #1 ans = {rd_valid, wr_accept, wr_invalid, rd_data};
        // released lines show the inverse so a stale value cannot pass
        {wr_req, wp_blocks, rd_req, rd_cmd} = {1'b0, ~c, ~d, ~p, 1'b0, ~c};
    endtask
endmodule
`default_nettype wire

// file: test/extended_command_write_guard_bench.sv
// bench: host model, word model and the guard under test
`default_nettype none
module extended_command_write_guard_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] WORD = ewp_pkg::CMD_EXT_WP, KEY = ewp_pkg::CMD_UNLOCK_CODE;
    logic                  clk = 1'b0, sys_rst = 1'b1, por = 1'b0, boot_load = 1'b0;
    logic [15:0]           nvm_ewp = '0, nvm_unlock_code = '0, mword, w; // mword: model word
    logic [18:0]           ans;                       // host capture
    logic                  wp;                        // random write-protect level
    integer                seed = 32'hCE84;           // fixed seed
    int                    error_cnt = 0, tests_run = 0;
    wire ewp_pkg::wr_req_t wr_req;
    wire logic             wp_blocks, rd_req, wr_accept, wr_invalid, rd_valid, unlock_active;
    wire logic [7:0]       rd_cmd;
    wire logic [15:0]      rd_data, extended_write_protect_word_word;
    // group commands and the bit that guards each
    logic [7:0]            gcmd [12] = '{8'h01, 8'h21, 8'h22, 8'h24, 8'h42, 8'h46, 8'h25,
                                         8'h33, 8'h58, 8'h60, 8'h99, 8'hEE};
    int                    gbit [12] = '{7, 12, 13, 11, 10, 9, 8, 6, 5, 4, 3, 2};
    logic [15:0]           codes [4] = '{16'h000F, 16'h001F, 16'h002F, 16'h00FF};
    pmbus_host_model i_host (.clk, .wr_req, .wp_blocks, .rd_req, .rd_cmd, .wr_accept,
        .wr_invalid, .rd_data, .rd_valid);
    extended_command_write_guard i_dut (.clk, .sys_rst, .por, .boot_load, .nvm_ewp,
        .nvm_unlock_code, .wr_req, .wp_blocks, .rd_req, .rd_cmd, .wr_accept, .wr_invalid,
        .rd_data, .rd_valid, .extended_write_protect_word_word, .unlock_active);
    always #4 clk = ~clk; // 125 MHz
    task automatic check(input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // write, e set when the guard must refuse it
    task automatic wchk(input logic [7:0] c, input logic [15:0] d, input logic p, e);
        i_host.xfer(1'b0, c, d, p, ans);
        check({14'h0, ans[17:16]}, {14'h0, ~e, e});
    endtask
    task automatic rdchk(input logic [7:0] c, input logic [15:0] e); // word read
        i_host.xfer(1'b1, c, 16'h0000, 1'b0, ans);
        check(ans[15:0], e);
        check({15'h0, ans[18]}, 16'h0001);
    endtask
    task automatic boot(input logic [15:0] ew, k); // one-cycle reload from backup
        @(posedge clk) #1 {nvm_ewp, nvm_unlock_code, boot_load} = {ew, k, 1'b1};
        @(posedge clk) #1 boot_load = 1'b0;
        mword = ew;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin // watchdog, far beyond the few hundred cycles needed
        #100000;
        error_cnt++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 sys_rst = 1'b0;
        boot(16'h2000, 16'h0000);
        check(extended_write_protect_word_word, mword);
        wchk(8'h22, 16'h0001, 1'b0, 1'b1);
        repeat (16) begin // random words, never self locking, random write-protect
            w = 16'($random(seed)) & 16'h7FFF;
            wp = 1'($random(seed));
            wchk(WORD, w, 1'b0, 1'b0);
            mword = w;
            rdchk(WORD, mword);
            wchk(ewp_pkg::CMD_WRITE_PROT, w, wp, mword[14]);
            foreach (gcmd[i]) wchk(gcmd[i], w, w[i], mword[gbit[i]] | w[i]);
        end
        wchk(WORD, 16'h0002, 1'b0, 1'b0);
        wchk(KEY, 16'h1234, 1'b0, 1'b1);
        rdchk(KEY, ewp_pkg::RD_UNLOCKED);
        wchk(WORD, 16'h8000, 1'b0, 1'b0);
        wchk(WORD, 16'h0000, 1'b0, 1'b1);
        wchk(KEY, 16'h0000, 1'b0, 1'b1);
        rdchk(WORD, 16'h8000);
        boot(16'h0000, 16'hA5C3);
        check({15'h0, unlock_active}, 16'h0001);
        wchk(WORD, 16'h0010, 1'b0, 1'b1);
        wchk(ewp_pkg::CMD_STORE_ALL, 16'h0000, 1'b0, 1'b1);
        foreach (codes[k]) begin // three misses, then the right key comes too late
            rdchk(KEY, codes[k]);
            w = (k == 3) ? 16'hA5C3 : 16'h0001;
            i_host.xfer(1'b0, KEY, w, 1'b0, ans);
        end
        rdchk(KEY, ewp_pkg::RD_LOCKED3);
        wchk(WORD, 16'h0123, 1'b0, 1'b1);
        @(posedge clk) #1 por = 1'b1;
        @(posedge clk) #1 por = 1'b0;
        boot(16'h0000, 16'hA5C3);
        i_host.xfer(1'b0, KEY, 16'hA5C3, 1'b0, ans);
        rdchk(KEY, ewp_pkg::RD_UNLOCKED);
        check({15'h0, unlock_active}, 16'h0000);
        wchk(WORD, 16'h0123, 1'b0, 1'b0);
        rdchk(WORD, 16'h0123);
        test_done;
    end
endmodule
`default_nettype wire
